// ==== src/lps_regs.sv ====
// Register slice, LED pulse train and wait timer of the light and proximity sensor.
// Assumes the serial front end turns each byte access into one-cycle read or write strobes.
`include "lps_map.svh"
module lps_regs #(
    parameter int WAIT_STEP_CYC = `LPS_WAIT_STEP_CYC,
    parameter int PULSE_PERIOD_CYC = `LPS_PULSE_PERIOD_CYC,
    parameter logic [7:0] PART_ID = 8'hA5
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    input wire logic near_sat_i,
    input wire logic near_irq_i,
    input wire logic light_irq_i,
    input wire logic near_done_i,
    input wire logic light_done_i,
    input wire logic [15:0] light0_i,
    input wire logic [15:0] light1_i,
    input wire logic accum_start_i,
    input wire logic wait_start_i,
    input wire logic [7:0] wait_cycles_i,
    output logic led_drive_pin_o,
    output logic pulse_busy_o,
    output logic wait_busy_o,
    output logic wait_done_o,
    output logic [13:0] light_gain_x100_o,
    output logic [9:0] led_current_x10_o,
    output logic [1:0] near_gain_o,
    output logic near_use_ch1_o
);
    localparam int HALF = PULSE_PERIOD_CYC / 2;

    if (PULSE_PERIOD_CYC < 2 || PULSE_PERIOD_CYC > 65536 || WAIT_STEP_CYC < 1 || WAIT_STEP_CYC > 65535) begin : g_chk
        $error("Timing parameters out of range.");
    end

    logic [7:0] cfg_ff;
    logic [7:0] pulse_cnt_ff;
    logic [7:0] analog_ff;
    logic near_valid_ff;
    logic light_valid_ff;
    logic [15:0] light0_ff;
    logic [15:0] light1_ff;
    logic [7:0] shadow0_ff;
    logic [7:0] shadow1_ff;

    // Effective light gain in hundredths.
    function automatic logic [13:0] gain_x100(input logic [1:0] code, input logic red);
        logic [13:0] g;
        g = 14'h0000;
        unique case (code)
            2'h0: g = red ? 14'h0010 : 14'h0064;
            2'h1: g = red ? 14'h0080 : 14'h0320;
            2'h2: g = 14'h0640;
            2'h3: g = 14'h2EE0;
        endcase
        return g;
    endfunction : gain_x100

    // LED current in tenths of a milliamp.
    function automatic logic [9:0] cur_x10(input logic [1:0] code, input logic red);
        logic [9:0] c;
        c = 10'h000;
        unique case (code)
            2'h0: c = red ? 10'h06F : 10'h3E8;
            2'h1: c = red ? 10'h038 : 10'h1F4;
            2'h2: c = red ? 10'h01C : 10'h0FA;
            2'h3: c = red ? 10'h00E : 10'h07D;
        endcase
        return c;
    endfunction : cur_x10

    wire logic wr_cfg = wr_en_i && reg_addr_i == `LPS_ADDR_CFG;
    wire logic wr_pulse = wr_en_i && reg_addr_i == `LPS_ADDR_PULSE;
    wire logic wr_analog = wr_en_i && reg_addr_i == `LPS_ADDR_ANALOG;

    // Only the three writable registers decode writes; all others drop them.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg_ff <= `LPS_RST_BYTE;
            pulse_cnt_ff <= `LPS_RST_BYTE;
            analog_ff <= `LPS_RST_BYTE;
        end else begin
            if (wr_cfg) begin
                cfg_ff <= wr_data_i;
            end
            if (wr_pulse) begin
                pulse_cnt_ff <= wr_data_i;
            end
            if (wr_analog) begin
                analog_ff <= wr_data_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            light_gain_x100_o <= 14'h0064;
            led_current_x10_o <= 10'h3E8;
            near_gain_o <= 2'h0;
            near_use_ch1_o <= 1'b0;
        end else begin
            light_gain_x100_o <= gain_x100(analog_ff[1:0], cfg_ff[`LPS_BIT_GAIN_RED]);
            led_current_x10_o <= cur_x10(analog_ff[7:6], cfg_ff[`LPS_BIT_DRV_RED]);
            near_gain_o <= analog_ff[3:2];
            near_use_ch1_o <= analog_ff[5:4] == `LPS_DIODE_CH1;
        end
    end

    // Valid flags are set-only, a new result simply re-sets them.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            near_valid_ff <= 1'b0;
            light_valid_ff <= 1'b0;
            light0_ff <= 16'h0000;
            light1_ff <= 16'h0000;
        end else begin
            if (near_done_i) begin
                near_valid_ff <= 1'b1;
            end
            if (light_done_i) begin
                light_valid_ff <= 1'b1;
                light0_ff <= light0_i;
                light1_ff <= light1_i;
            end
        end
    end

    // Shadows decouple the high byte from results landing between the two reads.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            shadow0_ff <= `LPS_RST_BYTE;
            shadow1_ff <= `LPS_RST_BYTE;
        end else if (rd_en_i) begin
            if (reg_addr_i == `LPS_ADDR_L0_LO) begin
                shadow0_ff <= light0_ff[15:8];
            end
            if (reg_addr_i == `LPS_ADDR_L1_LO) begin
                shadow1_ff <= light1_ff[15:8];
            end
        end
    end

    logic [7:0] status_w;
    always_comb begin
        status_w = 8'h00;
        status_w[`LPS_BIT_SAT] = near_sat_i;
        status_w[`LPS_BIT_NEAR_IRQ] = near_irq_i;
        status_w[`LPS_BIT_LIGHT_IRQ] = light_irq_i;
        status_w[`LPS_BIT_NEAR_VAL] = near_valid_ff;
        status_w[`LPS_BIT_LIGHT_VAL] = light_valid_ff;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en_i) begin
            unique case (reg_addr_i)
                `LPS_ADDR_CFG: rd_data_o <= cfg_ff;
                `LPS_ADDR_PULSE: rd_data_o <= pulse_cnt_ff;
                `LPS_ADDR_ANALOG: rd_data_o <= analog_ff;
                `LPS_ADDR_ID: rd_data_o <= PART_ID;
                `LPS_ADDR_STATUS: rd_data_o <= status_w;
                `LPS_ADDR_L0_LO: rd_data_o <= light0_ff[7:0];
                `LPS_ADDR_L0_HI: rd_data_o <= shadow0_ff;
                `LPS_ADDR_L1_LO: rd_data_o <= light1_ff[7:0];
                `LPS_ADDR_L1_HI: rd_data_o <= shadow1_ff;
                default: rd_data_o <= 8'h00;
            endcase
        end
    end

    lps_pkg::lps_pulse_t state_ff;
    lps_pkg::lps_pulse_t nxt_state;
    logic [15:0] phase_ff;
    logic [15:0] nxt_phase;
    logic [7:0] left_ff;
    logic [7:0] nxt_left;

    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_left = left_ff;
        unique case (state_ff)
            lps_pkg::P_IDLE: begin
                if (accum_start_i && pulse_cnt_ff != 8'h00) begin
                    nxt_state = lps_pkg::P_HIGH;
                    nxt_left = pulse_cnt_ff;
                    nxt_phase = 16'(HALF - 1);
                end
            end
            lps_pkg::P_HIGH: begin
                if (phase_ff == 16'h0000) begin
                    nxt_state = lps_pkg::P_LOW;
                    nxt_phase = 16'(PULSE_PERIOD_CYC - HALF - 1);
                end else begin
                    nxt_phase = phase_ff - 16'h0001;
                end
            end
            lps_pkg::P_LOW: begin
                if (phase_ff != 16'h0000) begin
                    nxt_phase = phase_ff - 16'h0001;
                end else if (left_ff == 8'h01) begin
                    nxt_state = lps_pkg::P_IDLE;
                    nxt_left = 8'h00;
                end else begin
                    nxt_state = lps_pkg::P_HIGH;
                    nxt_left = left_ff - 8'h01;
                    nxt_phase = 16'(HALF - 1);
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_ff <= lps_pkg::P_IDLE;
            phase_ff <= 16'h0000;
            left_ff <= 8'h00;
            led_drive_pin_o <= 1'b0;
            pulse_busy_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            left_ff <= nxt_left;
            led_drive_pin_o <= nxt_state == lps_pkg::P_HIGH;
            pulse_busy_o <= nxt_state != lps_pkg::P_IDLE;
        end
    end

    // Wait timer: steps of one base wait each, twelve times as many when extended.
    logic [11:0] steps_ff;
    logic [15:0] step_tmr_ff;
    logic [11:0] base_steps;
    assign base_steps = 12'h100 - {4'h0, wait_cycles_i};

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            steps_ff <= 12'h000;
            step_tmr_ff <= 16'h0000;
            wait_busy_o <= 1'b0;
            wait_done_o <= 1'b0;
        end else begin
            wait_done_o <= 1'b0;
            if (wait_start_i && !wait_busy_o) begin
                steps_ff <= cfg_ff[`LPS_BIT_WAIT_EXT] ? 12'(base_steps * `LPS_WAIT_EXT_MUL) : base_steps;
                step_tmr_ff <= 16'(WAIT_STEP_CYC - 1);
                wait_busy_o <= 1'b1;
            end else if (wait_busy_o) begin
                if (step_tmr_ff != 16'h0000) begin
                    step_tmr_ff <= step_tmr_ff - 16'h0001;
                end else if (steps_ff == 12'h001) begin
                    wait_busy_o <= 1'b0;
                    wait_done_o <= 1'b1;
                end else begin
                    steps_ff <= steps_ff - 12'h001;
                    step_tmr_ff <= 16'(WAIT_STEP_CYC - 1);
                end
            end
        end
    end

    // Helper counters watched only by the checks below.
    logic [15:0] hi_len_ff;
    logic [8:0] pulses_seen_ff;
    logic [7:0] pulses_req_ff;
    // Thirty-two bits, since a full extended wait at the default step length exceeds 24 bits.
    logic [31:0] wait_len_ff;
    logic [31:0] wait_req_ff;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hi_len_ff <= 16'h0000;
            pulses_seen_ff <= 9'h000;
            pulses_req_ff <= 8'h00;
            wait_len_ff <= 32'h00000000;
            wait_req_ff <= 32'h00000000;
        end else begin
            hi_len_ff <= led_drive_pin_o ? hi_len_ff + 16'h0001 : 16'h0000;
            if (!pulse_busy_o) begin
                pulses_seen_ff <= 9'h000;
                pulses_req_ff <= pulse_cnt_ff;
            end else if (led_drive_pin_o && hi_len_ff == 16'h0000) begin
                pulses_seen_ff <= pulses_seen_ff + 9'h001;
            end
            if (!wait_busy_o) begin
                wait_len_ff <= 32'h00000000;
                wait_req_ff <= 32'(base_steps * (cfg_ff[`LPS_BIT_WAIT_EXT] ? `LPS_WAIT_EXT_MUL : 1) * WAIT_STEP_CYC);
            end else begin
                wait_len_ff <= wait_len_ff + 32'h00000001;
            end
        end
    end

    a_pulse_high_len: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(led_drive_pin_o) |-> hi_len_ff == 16'(HALF)) else $error("LED pulse width wrong.");
    a_pulse_total: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(pulse_busy_o) |-> $past(pulses_seen_ff) == {1'b0, pulses_req_ff}) else $error("Pulse count wrong.");
    a_wait_length: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(wait_done_o) |-> $past(wait_len_ff) + 32'h00000001 == wait_req_ff) else $error("Wait length wrong.");
    a_id_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_en_i && reg_addr_i == `LPS_ADDR_ID |=> rd_data_o == PART_ID) else $error("Identity read wrong.");
    a_status_rsvd: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_en_i && reg_addr_i == `LPS_ADDR_STATUS |=> rd_data_o[7] == 1'b0 && rd_data_o[3:2] == 2'h0)
        else $error("Reserved status bits set.");
    a_status_flags: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_en_i && reg_addr_i == `LPS_ADDR_STATUS |=> rd_data_o[6:4] == $past({near_sat_i, near_irq_i, light_irq_i}))
        else $error("Status flags wrong.");
    a_valid_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        near_done_i || near_valid_ff |=> near_valid_ff) else $error("Valid flag lost.");
    a_shadow_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_en_i && reg_addr_i == `LPS_ADDR_L0_LO ##1 rd_en_i && reg_addr_i == `LPS_ADDR_L0_HI
        |=> rd_data_o == $past(light0_ff[15:8], 2)) else $error("Shadow byte incoherent.");
    a_cfg_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_cfg ##1 rd_en_i && reg_addr_i == `LPS_ADDR_CFG && !wr_en_i |=> rd_data_o == $past(wr_data_i, 2))
        else $error("Config write lost.");
endmodule : lps_regs

// ==== pkg/lps_map.svh ====
// Offsets, field positions, reset values and timing counts of the sensor register slice.
// Assumes a 10 MHz clock and byte-wide register accesses at byte addresses.
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
`define LPS_ADDR_CFG 8'h0D
`define LPS_ADDR_PULSE 8'h0E
`define LPS_ADDR_ANALOG 8'h0F
`define LPS_ADDR_ID 8'h12
`define LPS_ADDR_STATUS 8'h13
`define LPS_ADDR_L0_LO 8'h14
`define LPS_ADDR_L0_HI 8'h15
`define LPS_ADDR_L1_LO 8'h16
`define LPS_ADDR_L1_HI 8'h17
`define LPS_BIT_GAIN_RED 2
`define LPS_BIT_WAIT_EXT 1
`define LPS_BIT_DRV_RED 0
`define LPS_BIT_SAT 6
`define LPS_BIT_NEAR_IRQ 5
`define LPS_BIT_LIGHT_IRQ 4
`define LPS_BIT_NEAR_VAL 1
`define LPS_BIT_LIGHT_VAL 0
`define LPS_RST_BYTE 8'h00
`define LPS_DIODE_CH1 2'h2
`define LPS_WAIT_EXT_MUL 12
`define LPS_CLK_HZ 10000000
`define LPS_CLK_NS 100
`define LPS_WAIT_STEP_NS 2730000
`define LPS_WAIT_STEP_CYC ((`LPS_WAIT_STEP_NS + `LPS_CLK_NS - 1) / `LPS_CLK_NS)
`define LPS_PULSE_RATE_HZ 62500
`define LPS_PULSE_PERIOD_CYC (`LPS_CLK_HZ / `LPS_PULSE_RATE_HZ)
`endif

// ==== pkg/lps_pkg.sv ====
// Types shared by the sensor register slice.
// Assumes nothing beyond a SystemVerilog compiler.
package lps_pkg;
    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_HIGH = 3'b010,
        P_LOW = 3'b100
    } lps_pulse_t;
endpackage : lps_pkg

// ==== tb/lps_host.sv ====
// Host model that reaches the sensor registers through byte read and write strobes.
// Assumes the bench pops exp_q once for every read result that appears.
module lps_host (
    input wire logic clock_i,
    output logic [7:0] reg_addr_o,
    output logic wr_en_o,
    output logic [7:0] wr_data_o,
    output logic rd_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] exp_q[$];
    initial begin
        reg_addr_o = 8'h00;
        wr_en_o = 1'b0;
        wr_data_o = 8'h00;
        rd_en_o = 1'b0;
    end
    // Every access holds its strobe for exactly one edge, as the register port expects.
    task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] val);
        @(posedge clock_i);
        #1;
        reg_addr_o = addr;
        wr_en_o = we;
        rd_en_o = !we;
        wr_data_o = we ? val : ~wr_data_o;
        if (!we) exp_q.push_back(val);
    endtask : xfer
    // A released bus shows inverted values so that stale data cannot pass for good data.
    task automatic idle();
        @(posedge clock_i);
        #1;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        reg_addr_o = ~reg_addr_o;
        wr_data_o = ~wr_data_o;
    endtask : idle
    task automatic wr(input logic [7:0] addr, input logic [7:0] val);
        xfer(1'b1, addr, val);
        idle();
    endtask : wr
    task automatic rd(input logic [7:0] addr, input logic [7:0] val);
        xfer(1'b0, addr, val);
        idle();
    endtask : rd
    task automatic wr_cfg(input logic [2:0] bits);
        xfer(1'b1, 8'h0D, {5'h00, bits});
        rd(8'h0D, {5'h00, bits});
    endtask : wr_cfg
    task automatic rd_pair(input logic [7:0] lo, input logic [15:0] val);
        xfer(1'b0, lo, val[7:0]);
        xfer(1'b0, lo + 8'h01, val[15:8]);
        idle();
    endtask : rd_pair
endmodule : lps_host

// ==== tb/testbench.sv ====
// Self-checking bench of the sensor register slice with shortened wait and pulse counts.
// Assumes the host model drives the register port and notes expected read data.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 5;
    localparam int PER = 8;
    localparam logic [7:0] ID = 8'h5C; // Arbitrary value.
    logic clock_i, rst_n_i, near_sat_i, near_irq_i, light_irq_i, near_done_i, light_done_i;
    logic accum_start_i, wait_start_i, rd_seen;
    logic [7:0] reg_addr, wr_data, wait_cycles_i, rd_data_o;
    logic wr_en, rd_en, led_o, pbusy_o, wbusy_o, wdone_o, ch1_o;
    logic [15:0] light0_i, light1_i, old0;
    logic [13:0] gain_o;
    logic [9:0] cur_o;
    logic [1:0] ngain_o;
    int errors = 0, checked = 0, seed = 57719, n, hi, rises;
    int gain_t[4] = '{100, 800, 1600, 12000};
    int cur_t[8] = '{1000, 500, 250, 125, 111, 56, 28, 14};
    lps_host host (.clock_i(clock_i), .reg_addr_o(reg_addr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en));
    lps_regs #(.WAIT_STEP_CYC(STEP), .PULSE_PERIOD_CYC(PER), .PART_ID(ID)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .wr_en_i(wr_en), .wr_data_i(wr_data),
        .rd_en_i(rd_en), .rd_data_o(rd_data_o), .near_sat_i(near_sat_i), .near_irq_i(near_irq_i),
        .light_irq_i(light_irq_i), .near_done_i(near_done_i), .light_done_i(light_done_i), .light0_i(light0_i),
        .light1_i(light1_i), .accum_start_i(accum_start_i), .wait_start_i(wait_start_i),
        .wait_cycles_i(wait_cycles_i), .led_drive_pin_o(led_o), .pulse_busy_o(pbusy_o), .wait_busy_o(wbusy_o),
        .wait_done_o(wdone_o), .light_gain_x100_o(gain_o), .led_current_x10_o(cur_o), .near_gain_o(ngain_o),
        .near_use_ch1_o(ch1_o));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // Read data is compared on the falling edge, well clear of the edge that launches it.
    always @(posedge clock_i) rd_seen <= rd_en;
    always @(negedge clock_i) begin
        if (rd_seen) check(rd_data_o, host.exp_q.pop_front());
    end
    task automatic pulse_in(ref logic sig);
        @(posedge clock_i);
        #1;
        sig = 1'b1;
        @(posedge clock_i);
        #1;
        sig = 1'b0;
    endtask : pulse_in
    initial begin
        #2_000_000;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {rst_n_i, near_sat_i, near_irq_i, light_irq_i, near_done_i, light_done_i} = 6'h00;
        {accum_start_i, wait_start_i} = 2'h0;
        light0_i = 16'h0000;
        light1_i = 16'h0000;
        wait_cycles_i = 8'hFE;
        repeat (5) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        foreach (gain_t[i]) host.rd(8'h0D + i[7:0], 8'h00);
        host.rd(8'h12, ID);
        host.rd(8'h13, 8'h00);
        host.rd(8'h15, 8'h00);
        host.rd(8'h40, 8'h00);
        check(gain_o, 16'd100);
        check(cur_o, 16'd1000);
        check(ngain_o, 2'h0);
        check(ch1_o, 1'b0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            host.wr_cfg({c[2] & ~c[1], 1'b0, c[0]});
            host.wr(8'h0F, {c[1:0], 2'h2, c[2:1], c[1:0]});
            host.rd(8'h0F, {c[1:0], 2'h2, c[2:1], c[1:0]});
            repeat (2) @(posedge clock_i);
            #1;
            check(gain_o, (c[2] & ~c[1]) ? (c[0] ? 16'd128 : 16'd16) : gain_t[c[1:0]]);
            check(cur_o, cur_t[{c[0], c[1:0]}]);
            check(ngain_o, c[2:1]);
            check(ch1_o, 1'b1);
        end
        $display("test gain and drive done");
        near_sat_i = 1'b1;
        near_irq_i = 1'b1;
        light_irq_i = 1'b1;
        light0_i = $random(seed);
        light1_i = $random(seed);
        pulse_in(near_done_i);
        pulse_in(light_done_i);
        host.rd(8'h13, 8'h73);
        host.wr(8'h13, 8'h00);
        host.wr(8'h12, 8'h00);
        host.wr(8'h14, 8'hFF);
        host.rd(8'h13, 8'h73);
        host.rd(8'h12, ID);
        host.rd_pair(8'h14, light0_i);
        host.rd_pair(8'h16, light1_i);
        old0 = light0_i;
        host.rd(8'h14, old0[7:0]);
        light0_i = ~old0;
        pulse_in(light_done_i);
        host.rd(8'h15, old0[15:8]);
        {near_sat_i, near_irq_i, light_irq_i} = 3'h0;
        host.rd(8'h13, 8'h03);
        $display("test status and results done");
        host.wr_cfg(3'h0);
        host.wr(8'h0F, 8'h20);
        host.wr(8'h0E, 8'h08);
        pulse_in(accum_start_i);
        n = 0;
        hi = 0;
        rises = 0;
        // A pulse starts where the LED is on after exactly one half period of on time per earlier pulse.
        while (pbusy_o === 1'b1 && n < 200) begin
            n++;
            if (led_o === 1'b1 && hi == (rises * PER / 2)) rises++;
            hi += led_o;
            if (n == 6) accum_start_i = 1'b1;
            if (n == 7) accum_start_i = 1'b0;
            @(posedge clock_i);
            #1;
        end
        check(n, 8 * PER);
        check(hi, 8 * PER / 2);
        check(rises, 8);
        check(cur_o, 16'd1000);
        $display("test pulse train done");
        for (int e = 0; e < 2; e++) begin
            host.wr_cfg({1'b0, e[0], 1'b0});
            pulse_in(wait_start_i);
            n = 0;
            while (wbusy_o === 1'b1 && n < 1000) begin
                n++;
                @(posedge clock_i);
                #1;
            end
            check(n, 2 * STEP * (e ? 12 : 1));
            check(wdone_o, 1'b1);
        end
        $display("test wait timer done");
        repeat (3) @(posedge clock_i);
        tally_and_finish();
    end
endmodule : testbench
